// ===== rtl/cbrtc_defs.vh
/*
  Constants of the calendar and binary real-time clock.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CBRTC_DEFS_VH
`define CBRTC_DEFS_VH

// Sub-clock edges per 128 Hz sub-second step
`define CBRTC_PRESC_DIV   256
`define CBRTC_PRESC_W     8
`define CBRTC_SUBSEC_MAX  7'h7f
// BCD limits
`define CBRTC_SEC_MAX     8'h59
`define CBRTC_MIN_MAX     8'h59
`define CBRTC_SEC_HALF    8'h30
`define CBRTC_HOUR24_MAX  8'h23
`define CBRTC_HOUR12_MAX  6'h12
`define CBRTC_HOUR12_PRE  6'h11
`define CBRTC_HOUR_PM_BIT 6
`define CBRTC_WDAY_MAX    8'h06
`define CBRTC_MON_MAX     8'h12
`define CBRTC_MON_FEB     8'h02
`define CBRTC_YEAR_MAX    8'h99
`define CBRTC_BCD_ZERO    8'h00
`define CBRTC_BCD_ONE     8'h01
// Reset time: year 00, January 1st, day 0, 00:00:00
`define CBRTC_RST_FIELD   8'h00
`define CBRTC_RST_DAYMON  8'h01
// Correction applied once every 60 seconds
`define CBRTC_CORR_LAST   6'h3b
// Alarm enable bit positions
`define CBRTC_ALM_SEC     0
`define CBRTC_ALM_MIN     1
`define CBRTC_ALM_HOUR    2
`define CBRTC_ALM_WDAY    3
`define CBRTC_ALM_DATE    4
`define CBRTC_ALM_MON     5
`define CBRTC_ALM_YEAR    6
// Periodic interrupt period codes
`define CBRTC_PRD_OFF     4'h0
`define CBRTC_PRD_256     4'h1
`define CBRTC_PRD_64      4'h2
`define CBRTC_PRD_32      4'h3
`define CBRTC_PRD_16      4'h4
`define CBRTC_PRD_8       4'h5
`define CBRTC_PRD_4       4'h6
`define CBRTC_PRD_2       4'h7
`define CBRTC_PRD_1S      4'h8
`define CBRTC_PRD_2S      4'h9
// Capture control: bit 0 enable, bits 2:1 edge select
`define CBRTC_CAP_EN      0
`define CBRTC_CAP_RISE    2'h1
`define CBRTC_CAP_FALL    2'h2
`define CBRTC_CAP_BOTH    2'h3

`endif

// ===== rtl/cbrtc_capture.v
/*
  One time-capture channel: latches the current time on an event edge.
  Assumes the event input is synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cbrtc_defs.vh"

module cbrtc_capture
(
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire        event_in,
  input  wire [2:0]  capture_control_in,
  input  wire        binary_mode_in,
  input  wire [7:0]  cur_sec_in,
  input  wire [7:0]  cur_min_in,
  input  wire [7:0]  cur_hour_in,
  input  wire [7:0]  cur_date_in,
  input  wire [7:0]  cur_mon_in,
  input  wire [31:0] cur_bin_in,
  output reg  [7:0]  captured_second_out,
  output reg  [7:0]  captured_minute_out,
  output reg  [7:0]  captured_hour_out,
  output reg  [7:0]  captured_date_out,
  output reg  [7:0]  captured_month_out,
  output reg         captured_flag_out
);

  reg        event_prev_ff;
  wire [1:0] edge_sel;
  wire       hit;

  assign edge_sel = capture_control_in[2:1];
  // Edge detect per selected polarity
  assign hit = capture_control_in[`CBRTC_CAP_EN] &
               ((edge_sel[0] & event_in & ~event_prev_ff) |
                (edge_sel[1] & ~event_in & event_prev_ff));

  ////////////////////////////////////////////////////////////////
  // latch on edge
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      event_prev_ff       <= 1'b0;
      captured_second_out <= `CBRTC_RST_FIELD;
      captured_minute_out <= `CBRTC_RST_FIELD;
      captured_hour_out   <= `CBRTC_RST_FIELD;
      captured_date_out   <= `CBRTC_RST_FIELD;
      captured_month_out  <= `CBRTC_RST_FIELD;
      captured_flag_out   <= 1'b0;
    end
    else
    begin
      event_prev_ff <= event_in;
      if (hit)
      begin
        if (binary_mode_in)
        begin
          captured_second_out <= cur_bin_in[7:0];
          captured_minute_out <= cur_bin_in[15:8];
          captured_hour_out   <= cur_bin_in[23:16];
          captured_date_out   <= cur_bin_in[31:24];
          captured_month_out  <= `CBRTC_RST_FIELD;
        end
        else
        begin
          captured_second_out <= cur_sec_in;
          captured_minute_out <= cur_min_in;
          captured_hour_out   <= cur_hour_in;
          captured_date_out   <= cur_date_in;
          captured_month_out  <= cur_mon_in;
        end
      end
      // Disabling the channel clears the flag and blocks any new set
      captured_flag_out <= hit | (captured_flag_out & capture_control_in[`CBRTC_CAP_EN]);
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cbrtc_top.v
/*
  Calendar / binary real-time clock core with time capture.
  Assumes all inputs synchronous to clk_in; the sub-clock is sampled as a level.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cbrtc_defs.vh"

module cbrtc_top
#(
  parameter CHANNELS = 3
)
(
  input  wire                  clk_in,
  input  wire                  sys_rst_in,
  input  wire                  subclock_input_in,
  input  wire                  count_start_in,
  input  wire                  binary_mode_in,
  input  wire                  hour24_in,
  input  wire                  adjust30_in,
  input  wire                  time_load_in,
  input  wire [7:0]            load_year_in,
  input  wire [7:0]            load_month_in,
  input  wire [7:0]            load_date_in,
  input  wire [7:0]            load_wday_in,
  input  wire [7:0]            load_hour_in,
  input  wire [7:0]            load_minute_in,
  input  wire [7:0]            load_second_in,
  input  wire [31:0]           load_binary_in,
  input  wire                  corr_enable_in,
  input  wire                  corr_add_in,
  input  wire [5:0]            corr_value_in,
  input  wire                  clkout_enable_in,
  input  wire                  clkout_64hz_in,
  input  wire [3:0]            periodic_sel_in,
  input  wire [6:0]            alarm_enable_in,
  input  wire [7:0]            alarm_year_in,
  input  wire [7:0]            alarm_month_in,
  input  wire [7:0]            alarm_date_in,
  input  wire [7:0]            alarm_wday_in,
  input  wire [7:0]            alarm_hour_in,
  input  wire [7:0]            alarm_minute_in,
  input  wire [7:0]            alarm_second_in,
  input  wire [31:0]           alarm_binary_in,
  input  wire [31:0]           alarm_binary_mask_in,
  input  wire                  subsecond_read_in,
  input  wire [CHANNELS-1:0]   capture_event_in,
  input  wire [3*CHANNELS-1:0] capture_control_y_in,
  output reg  [7:0]            year_out,
  output reg  [7:0]            month_out,
  output reg  [7:0]            date_out,
  output reg  [7:0]            wday_out,
  output reg  [7:0]            hour_out,
  output reg  [7:0]            minute_out,
  output reg  [7:0]            second_out,
  output reg  [31:0]           binary_count_out,
  output reg  [6:0]            subsecond_count_reg_out,
  output reg                   clock_out,
  output reg                   alarm_irq_out,
  output reg                   periodic_irq_out,
  output reg                   carry_irq_out,
  output wire [8*CHANNELS-1:0] captured_second_y_out,
  output wire [8*CHANNELS-1:0] captured_minute_y_out,
  output wire [8*CHANNELS-1:0] captured_hour_y_out,
  output wire [8*CHANNELS-1:0] captured_date_y_out,
  output wire [8*CHANNELS-1:0] captured_month_y_out,
  output wire [CHANNELS-1:0]   captured_flag_y_out
);

  ////////////////////////////////////////////////////////////////
  // Helper functions

  // BCD increment of a two-digit value
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last date of a month in BCD, years 00..99
  function [7:0] month_last;
    input [7:0] mon;
    input [7:0] yr;
    reg         leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
                     (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
        `CBRTC_MON_FEB: month_last = leap ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
        default: month_last = 8'h31;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Prescaler and sub-second counter

  reg                      sub_prev_ff;
  reg [`CBRTC_PRESC_W-1:0] presc_ff;
  reg [5:0]                stall_ff;
  reg [5:0]                corr_cnt_ff;
  reg [6:0]                subsec_ff;
  wire                     sub_edge;
  wire                     presc_step;
  wire                     presc_last;
  wire                     tick128;
  wire                     tick256;
  wire                     sec_tick;
  wire                     corr_point;
  wire [6:0]               subsec_nxt;

  assign sub_edge   = subclock_input_in & ~sub_prev_ff;
  assign presc_step = sub_edge & count_start_in & (stall_ff == 6'h00);
  assign presc_last = (presc_ff == `CBRTC_PRESC_DIV - 1);
  assign tick128    = presc_step & presc_last;
  assign tick256    = presc_step & (presc_last | (presc_ff == `CBRTC_PRESC_DIV / 2 - 1));
  assign subsec_nxt = subsec_ff + 7'h01;
  assign sec_tick   = tick128 & (subsec_ff == `CBRTC_SUBSEC_MAX);
  assign corr_point = sec_tick & corr_enable_in & (corr_cnt_ff == `CBRTC_CORR_LAST);

  always @(posedge clk_in)
  begin
    if (sys_rst_in || time_load_in)
    begin
      sub_prev_ff <= 1'b0;
      presc_ff    <= {`CBRTC_PRESC_W{1'b0}};
      stall_ff    <= 6'h00;
      corr_cnt_ff <= 6'h00;
      subsec_ff   <= 7'h00;
    end
    else
    begin
      sub_prev_ff <= subclock_input_in;
      if (sub_edge && count_start_in && stall_ff != 6'h00)
        stall_ff <= stall_ff - 6'h01;
      else if (corr_point && !corr_add_in)
        stall_ff <= corr_value_in;
      if (corr_point && corr_add_in)
        presc_ff <= {{(`CBRTC_PRESC_W-6){1'b0}}, corr_value_in};
      else if (presc_step)
        presc_ff <= presc_last ? {`CBRTC_PRESC_W{1'b0}} : presc_ff + 1'b1;
      if (sec_tick)
        corr_cnt_ff <= (corr_cnt_ff == `CBRTC_CORR_LAST) ? 6'h00 : corr_cnt_ff + 6'h01;
      if (tick128)
        subsec_ff <= subsec_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Time counters: next-state cascade

  reg [7:0]  sec_ff, min_ff, hour_ff, wday_ff, date_ff, mon_ff, year_ff;
  reg [31:0] bin_ff;
  reg [7:0]  nxt_sec, nxt_min, nxt_hour, nxt_wday, nxt_date, nxt_mon, nxt_year;
  reg [31:0] nxt_bin;
  reg        c_min, c_hour, c_day, c_mon, c_year;

  always @*
  begin
    nxt_sec  = sec_ff;
    nxt_min  = min_ff;
    nxt_hour = hour_ff;
    nxt_wday = wday_ff;
    nxt_date = date_ff;
    nxt_mon  = mon_ff;
    nxt_year = year_ff;
    nxt_bin  = bin_ff;
    c_min    = 1'b0;
    c_hour   = 1'b0;
    c_day    = 1'b0;
    c_mon    = 1'b0;
    c_year   = 1'b0;
    if (sec_tick && binary_mode_in)
      nxt_bin = bin_ff + 32'h1;
    else if (sec_tick)
    begin
      c_min   = (sec_ff == `CBRTC_SEC_MAX);
      nxt_sec = c_min ? `CBRTC_BCD_ZERO : bcd_inc(sec_ff);
    end
    else if (adjust30_in && !binary_mode_in)
    begin
      nxt_sec = `CBRTC_BCD_ZERO;
      c_min   = (sec_ff >= `CBRTC_SEC_HALF);
    end
    if (c_min)
    begin
      c_hour  = (min_ff == `CBRTC_MIN_MAX);
      nxt_min = c_hour ? `CBRTC_BCD_ZERO : bcd_inc(min_ff);
    end
    if (c_hour && hour24_in)
    begin
      c_day    = (hour_ff == `CBRTC_HOUR24_MAX);
      nxt_hour = c_day ? `CBRTC_BCD_ZERO : bcd_inc(hour_ff);
    end
    else if (c_hour)
    begin
      if (hour_ff[5:0] == `CBRTC_HOUR12_MAX)
        nxt_hour = `CBRTC_BCD_ONE | {hour_ff[7:6], 6'h00};
      else if (hour_ff[5:0] == `CBRTC_HOUR12_PRE)
      begin
        nxt_hour = hour_ff ^ 8'h03;
        nxt_hour[`CBRTC_HOUR_PM_BIT] = ~hour_ff[`CBRTC_HOUR_PM_BIT];
        c_day    = hour_ff[`CBRTC_HOUR_PM_BIT];
      end
      else
        nxt_hour = (bcd_inc({2'h0, hour_ff[5:0]}) | {hour_ff[7:6], 6'h00}) & 8'h7f;
    end
    if (c_day)
    begin
      nxt_wday = (wday_ff == `CBRTC_WDAY_MAX) ? `CBRTC_BCD_ZERO : wday_ff + 8'h01;
      c_mon    = (date_ff == month_last(mon_ff, year_ff));
      nxt_date = c_mon ? `CBRTC_BCD_ONE : bcd_inc(date_ff);
    end
    if (c_mon)
    begin
      c_year  = (mon_ff == `CBRTC_MON_MAX);
      nxt_mon = c_year ? `CBRTC_BCD_ONE : bcd_inc(mon_ff);
    end
    if (c_year)
      nxt_year = (year_ff == `CBRTC_YEAR_MAX) ? `CBRTC_BCD_ZERO : bcd_inc(year_ff);
    if (time_load_in)
    begin
      nxt_sec  = load_second_in;
      nxt_min  = load_minute_in;
      nxt_hour = load_hour_in;
      nxt_wday = load_wday_in;
      nxt_date = load_date_in;
      nxt_mon  = load_month_in;
      nxt_year = load_year_in;
      nxt_bin  = load_binary_in;
    end
  end

  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      sec_ff  <= `CBRTC_RST_FIELD;
      min_ff  <= `CBRTC_RST_FIELD;
      hour_ff <= `CBRTC_RST_FIELD;
      wday_ff <= `CBRTC_RST_FIELD;
      date_ff <= `CBRTC_RST_DAYMON;
      mon_ff  <= `CBRTC_RST_DAYMON;
      year_ff <= `CBRTC_RST_FIELD;
      bin_ff  <= 32'h0;
    end
    else
    begin
      sec_ff  <= nxt_sec;
      min_ff  <= nxt_min;
      hour_ff <= nxt_hour;
      wday_ff <= nxt_wday;
      date_ff <= nxt_date;
      mon_ff  <= nxt_mon;
      year_ff <= nxt_year;
      bin_ff  <= nxt_bin;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Alarm, periodic and carry events

  reg        alm_chk_ff;
  wire [6:0] fld_eq;
  wire       cal_match;
  wire       bin_match;
  reg  [6:0] prd_mask;
  reg        prd_hit;

  assign fld_eq[`CBRTC_ALM_SEC]  = (sec_ff == alarm_second_in);
  assign fld_eq[`CBRTC_ALM_MIN]  = (min_ff == alarm_minute_in);
  assign fld_eq[`CBRTC_ALM_HOUR] = (hour_ff == alarm_hour_in);
  assign fld_eq[`CBRTC_ALM_WDAY] = (wday_ff == alarm_wday_in);
  assign fld_eq[`CBRTC_ALM_DATE] = (date_ff == alarm_date_in);
  assign fld_eq[`CBRTC_ALM_MON]  = (mon_ff == alarm_month_in);
  assign fld_eq[`CBRTC_ALM_YEAR] = (year_ff == alarm_year_in);
  assign cal_match = (alarm_enable_in != 7'h00) & (&(fld_eq | ~alarm_enable_in));
  assign bin_match = (alarm_binary_mask_in != 32'h0) &
                     (((bin_ff ^ alarm_binary_in) & alarm_binary_mask_in) == 32'h0);

  always @*
  begin
    prd_mask = 7'h00;
    prd_hit  = 1'b0;
    case (periodic_sel_in)
      `CBRTC_PRD_256: prd_hit = tick256;
      `CBRTC_PRD_64:  prd_mask = 7'h01;
      `CBRTC_PRD_32:  prd_mask = 7'h03;
      `CBRTC_PRD_16:  prd_mask = 7'h07;
      `CBRTC_PRD_8:   prd_mask = 7'h0f;
      `CBRTC_PRD_4:   prd_mask = 7'h1f;
      `CBRTC_PRD_2:   prd_mask = 7'h3f;
      `CBRTC_PRD_1S:  prd_mask = 7'h7f;
      `CBRTC_PRD_2S:  prd_hit = sec_tick & (binary_mode_in ? bin_ff[0] : sec_ff[0]);
      default:        prd_hit = 1'b0;
    endcase
    if (prd_mask != 7'h00)
      prd_hit = tick128 & ((subsec_nxt & prd_mask) == 7'h00);
  end

  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      alm_chk_ff       <= 1'b0;
      alarm_irq_out    <= 1'b0;
      periodic_irq_out <= 1'b0;
      carry_irq_out    <= 1'b0;
    end
    else
    begin
      alm_chk_ff       <= sec_tick | time_load_in | (adjust30_in & ~binary_mode_in);
      alarm_irq_out    <= alm_chk_ff & (binary_mode_in ? bin_match : cal_match);
      periodic_irq_out <= prd_hit;
      carry_irq_out    <= sec_tick | (tick128 & subsecond_read_in);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Visible time, sub-second count and clock output

  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      year_out                <= `CBRTC_RST_FIELD;
      month_out               <= `CBRTC_RST_DAYMON;
      date_out                <= `CBRTC_RST_DAYMON;
      wday_out                <= `CBRTC_RST_FIELD;
      hour_out                <= `CBRTC_RST_FIELD;
      minute_out              <= `CBRTC_RST_FIELD;
      second_out              <= `CBRTC_RST_FIELD;
      binary_count_out        <= 32'h0;
      subsecond_count_reg_out <= 7'h00;
      clock_out               <= 1'b0;
    end
    else
    begin
      year_out                <= year_ff;
      month_out               <= mon_ff;
      date_out                <= date_ff;
      wday_out                <= wday_ff;
      hour_out                <= hour_ff;
      minute_out              <= min_ff;
      second_out              <= sec_ff;
      binary_count_out        <= bin_ff;
      subsecond_count_reg_out <= subsec_ff;
      clock_out <= clkout_enable_in & (clkout_64hz_in ? subsec_ff[0] : subsec_ff[6]);
    end
  end

  ////////////////////////////////////////////////////////////////
  // capture channels
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1)
    begin : g_cap
      cbrtc_capture u_cap
      (
        .clk_in              (clk_in),
        .sys_rst_in          (sys_rst_in),
        .event_in            (capture_event_in[gi]),
        .capture_control_in  (capture_control_y_in[3*gi +: 3]),
        .binary_mode_in      (binary_mode_in),
        .cur_sec_in          (sec_ff),
        .cur_min_in          (min_ff),
        .cur_hour_in         (hour_ff),
        .cur_date_in         (date_ff),
        .cur_mon_in          (mon_ff),
        .cur_bin_in          (bin_ff),
        .captured_second_out (captured_second_y_out[8*gi +: 8]),
        .captured_minute_out (captured_minute_y_out[8*gi +: 8]),
        .captured_hour_out   (captured_hour_y_out[8*gi +: 8]),
        .captured_date_out   (captured_date_y_out[8*gi +: 8]),
        .captured_month_out  (captured_month_y_out[8*gi +: 8]),
        .captured_flag_out   (captured_flag_y_out[gi])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// ===== verif/cbrtc_chk.sv
/*
  Checker of the real-time clock core: pulses, hold, causes, capture.
  Assumes binding to cbrtc_top and its synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cbrtc_chk
#(
  parameter CHANNELS = 3
)
(
  input wire logic                  clk_in,
  input wire logic                  sys_rst_in,
  input wire logic                  count_start_in,
  input wire logic                  time_load_in,
  input wire logic                  adjust30_in,
  input wire logic [3:0]            periodic_sel_in,
  input wire logic [6:0]            alarm_enable_in,
  input wire logic [31:0]           alarm_binary_mask_in,
  input wire logic                  subsecond_read_in,
  input wire logic [CHANNELS-1:0]   capture_event_in,
  input wire logic [3*CHANNELS-1:0] capture_control_y_in,
  input wire logic [6:0]            subsecond_count_reg_out,
  input wire logic                  alarm_irq_out,
  input wire logic                  periodic_irq_out,
  input wire logic                  carry_irq_out,
  input wire logic [CHANNELS-1:0]   captured_flag_y_out
);
  // One domain; reset silences every check
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  //////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses, sub-second hold and causes
  carry_pulse_a: assert property (carry_irq_out |=> !carry_irq_out)
    else $error("carry pulse too long");
  carry_cause_a: assert property (carry_irq_out |->
    ($past(subsecond_read_in) || subsecond_count_reg_out == 7'h7f)
    && ($past(count_start_in) || $past(count_start_in, 2)))
    else $error("carry without cause");
  stop_hold_a: assert property (
    (!count_start_in && !time_load_in && !adjust30_in)[*2] |=> $stable(subsecond_count_reg_out))
    else $error("sub-second moved while stopped");
  alarm_cause_a: assert property (alarm_irq_out |->
    $past(time_load_in, 2) || $past(adjust30_in, 2) || $past(carry_irq_out))
    else $error("alarm without time change");
  alarm_off_a: assert property (
    (alarm_enable_in == 7'h00 && alarm_binary_mask_in == 32'h0)[*3] |-> !alarm_irq_out)
    else $error("alarm with nothing enabled");
  prd_off_a: assert property ((periodic_sel_in == 4'h0)[*2] |-> !periodic_irq_out)
    else $error("periodic while off");
  //////////////////////////////////////////////////////////////////////////////
  // Capture channel zero
  cap_rise_a: assert property (
    $rose(capture_event_in[0]) && capture_control_y_in[2:0] == 3'h3 |=> captured_flag_y_out[0])
    else $error("rising edge not captured");
  cap_off_a: assert property (!capture_control_y_in[0] |=> !captured_flag_y_out[0])
    else $error("flag set on disabled channel");
  // Main scenarios reached
  cover property (carry_irq_out);
  cover property (alarm_irq_out);
  cover property (captured_flag_y_out[0]);
endmodule
bind cbrtc_top cbrtc_chk #(.CHANNELS(CHANNELS)) cbrtc_chk_i (.*);
`default_nettype wire

// ===== verif/cbrtc_bench.sv
/*
  Self-checking bench of the real-time clock core.
  Assumes the checker binds itself to the core.
*/
`timescale 1ns/1ps
`default_nettype none
module cbrtc_bench;
  logic        clk_in, sys_rst_in, subclock_input_in, count_start_in, binary_mode_in;
  logic        hour24_in, adjust30_in, time_load_in, corr_enable_in, corr_add_in, sub_run;
  logic        clkout_enable_in, clkout_64hz_in, subsecond_read_in, clock_out;
  logic        alarm_irq_out, periodic_irq_out, carry_irq_out;
  logic [7:0]  load_year_in, load_month_in, load_date_in, load_wday_in, load_hour_in;
  logic [7:0]  load_minute_in, load_second_in, alarm_year_in, alarm_month_in, alarm_date_in;
  logic [7:0]  alarm_wday_in, alarm_hour_in, alarm_minute_in, alarm_second_in, year_out;
  logic [7:0]  month_out, date_out, wday_out, hour_out, minute_out, second_out;
  logic [31:0] load_binary_in, alarm_binary_in, alarm_binary_mask_in, binary_count_out;
  logic [23:0] captured_second_y_out, captured_minute_y_out, captured_hour_y_out;
  logic [23:0] captured_date_y_out, captured_month_y_out;
  logic [6:0]  alarm_enable_in, subsecond_count_reg_out;
  logic [5:0]  corr_value_in;
  logic [3:0]  periodic_sel_in;
  logic [8:0]  capture_control_y_in;
  logic [2:0]  capture_event_in, captured_flag_y_out;
  int          n_mismatch = 0, compares = 0, n_carry = 0, n_per = 0, n_alarm = 0, cyc = 0;

  cbrtc_top #(.CHANNELS(3)) cbrtc_top_i (.*);
  //////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock; sub-clock toggles each cycle while enabled
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (sub_run)
      subclock_input_in <= #1 ~subclock_input_in;
  // Pulses counted at mid-cycle; one second plus margin bounds the run
  always @(negedge clk_in)
  begin
    cyc++;
    if (carry_irq_out === 1'b1)
      n_carry++;
    if (periodic_irq_out === 1'b1)
      n_per++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Load a time, then count alarm pulses in the next four cycles
  task automatic load(input logic [7:0] y, mo, d, w, h, mi, s, input logic [31:0] b);
    {load_year_in, load_month_in, load_date_in, load_wday_in} = {y, mo, d, w};
    {load_hour_in, load_minute_in, load_second_in, load_binary_in} = {h, mi, s, b};
    time_load_in = 1'b1;
    step(1);
    time_load_in = 1'b0;
    n_alarm = 0;
    repeat (4)
    begin
      step(1);
      if (alarm_irq_out === 1'b1)
        n_alarm++;
    end
  endtask
  task automatic adj;
    adjust30_in = 1'b1;
    step(1);
    adjust30_in = 1'b0;
    step(3);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_adjust;
    for (int i = 0; i < 2; i++)
    begin
      load(8'h24, 8'h02, 8'h28, 8'h03, 8'h10, 8'h10, i ? 8'h29 : 8'h30, 32'h45);
      adj();
      chk("adj sec", second_out, 8'h00);
      chk("adj min", minute_out, i ? 8'h10 : 8'h11);
    end
    hour24_in = 1'b0;
    load(8'h24, 8'h02, 8'h28, 8'h03, 8'h52, 8'h59, 8'h30, 32'h45);
    adj();
    chk("adj 12h", hour_out, 8'h41);
    hour24_in = 1'b1;
    binary_mode_in = 1'b1;
    adj();
    chk("adj binary", binary_count_out, 32'h45);
    binary_mode_in = 1'b0;
    $display("test adjust done");
  endtask
  task t_capture;
    capture_control_y_in = 9'h143;
    load(8'h24, 8'h07, 8'h15, 8'h02, 8'h13, 8'h42, 8'h17, 32'h12345678);
    capture_event_in = 3'b011;
    step(3);
    chk("cap cal", {captured_month_y_out[7:0], captured_date_y_out[7:0], captured_hour_y_out[7:0],
      captured_minute_y_out[7:0], captured_second_y_out[7:0]}, 40'h0715134217);
    chk("cap flags", captured_flag_y_out, 3'b001);
    binary_mode_in = 1'b1;
    capture_event_in = 3'b111;
    step(2);
    capture_event_in = 3'b011;
    step(3);
    chk("cap bin", {captured_month_y_out[23:16], captured_date_y_out[23:16],
      captured_hour_y_out[23:16], captured_minute_y_out[23:16],
      captured_second_y_out[23:16]}, 40'h0012345678);
    chk("cap flags", captured_flag_y_out, 3'b101);
    chk("cap ch0 kept", captured_second_y_out[7:0], 8'h17);
    capture_control_y_in = 9'h000;
    step(2);
    chk("cap off", captured_flag_y_out, 3'b000);
    capture_event_in = 3'b000;
    $display("test capture done");
  endtask
  task t_alarm;
    alarm_enable_in = 7'h7f;
    alarm_binary_mask_in = 32'h000001ff;
    alarm_binary_in = 32'hfffffe78;
    for (int i = 0; i < 2; i++)
    begin
      load(8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, i ? 32'h12345778 : 32'h12345678);
      chk("alarm bin", n_alarm, i ? 0 : 1);
    end
    binary_mode_in = 1'b0;
    alarm_binary_mask_in = 32'h0;
    {alarm_second_in, alarm_date_in} = 16'h1715;
    for (int i = 0; i < 3; i++)
    begin
      alarm_enable_in = (i == 2) ? 7'h00 : 7'h11;
      load(8'h24, 8'h07, (i == 1) ? 8'h16 : 8'h15, 8'h02, 8'h13, 8'h42, 8'h17, 32'h0);
      chk("alarm cal", n_alarm, (i == 0) ? 1 : 0);
    end
    $display("test alarm done");
  endtask
  task t_stop;
    load(8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 32'h0);
    {count_start_in, subsecond_read_in, clkout_enable_in, clkout_64hz_in} = 4'b0111;
    sub_run = 1'b1;
    n_carry = 0;
    step(600);
    chk("stop carry", n_carry, 0);
    chk("stop sub", subsecond_count_reg_out, 7'h00);
    count_start_in = 1'b1;
    step(600);
    chk("read carry", n_carry, 1);
    chk("sub count", subsecond_count_reg_out, 7'h01);
    chk("clk 64", clock_out, 1'b1);
    clkout_64hz_in = 1'b0;
    step(2);
    chk("clk 1", clock_out, 1'b0);
    {sub_run, subsecond_read_in} = 2'b00;
    $display("test stop done");
  endtask
  task t_second;
    int i;
    periodic_sel_in = 4'h1;
    {alarm_enable_in, alarm_second_in, alarm_date_in} = {7'h11, 16'h0029};
    load(8'h24, 8'h02, 8'h28, 8'h03, 8'h23, 8'h59, 8'h59, 32'h0);
    {n_per, n_carry, i} = '0;
    sub_run = 1'b1;
    while (carry_irq_out !== 1'b1 && i < 70000)
    begin
      step(1);
      i++;
    end
    step(1);
    chk("alarm", alarm_irq_out, 1'b1);
    sub_run = 1'b0;
    step(2);
    chk("leap", {year_out, month_out, date_out, wday_out, hour_out, minute_out, second_out},
      56'h24022904000000);
    chk("periodic", n_per, 256);
    chk("carry", n_carry, 1);
    chk("sub wrap", subsecond_count_reg_out, 7'h00);
    $display("test second done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Reset, then every scenario in turn
  initial
  begin
    {clk_in, sys_rst_in, subclock_input_in, count_start_in, hour24_in} = 5'b01011;
    {binary_mode_in, adjust30_in, time_load_in, corr_enable_in, corr_add_in, sub_run} = '0;
    {clkout_enable_in, clkout_64hz_in, subsecond_read_in, corr_value_in} = '0;
    {load_year_in, load_month_in, load_date_in, load_wday_in, load_hour_in} = '0;
    {load_minute_in, load_second_in, load_binary_in, periodic_sel_in} = '0;
    {alarm_year_in, alarm_month_in, alarm_date_in, alarm_wday_in, alarm_hour_in} = '0;
    {alarm_minute_in, alarm_second_in, alarm_binary_in, alarm_binary_mask_in} = '0;
    {alarm_enable_in, capture_event_in, capture_control_y_in} = '0;
    step(12);
    sys_rst_in = 1'b0;
    step(1);
    chk("reset time", {year_out, month_out, date_out, wday_out, hour_out, minute_out,
      second_out, subsecond_count_reg_out}, 63'h0000808000000000);
    t_adjust;
    t_capture;
    t_alarm;
    t_stop;
    t_second;
    give_verdict;
  end
endmodule
`default_nettype wire
